// ---- include/rio_consts.svh ----
// robot i/o mode decoder: register offsets, field positions, codes, reset values
// assumes byte addressing on a 32-bit avalon-mm slave, one word per register
`ifndef RIO_CONSTS_SVH
`define RIO_CONSTS_SVH

// register byte offsets
`define RIO_OFS_SEL 5'h00
`define RIO_OFS_RAW 5'h04
`define RIO_OFS_IRQ_STAT 5'h08
`define RIO_OFS_IRQ_MASK 5'h0c
`define RIO_OFS_CTRL 5'h10

// selection register fields
`define RIO_SEL_CFG_LSB 0
`define RIO_SEL_WM_LSB 2
`define RIO_SEL_ROLE1_LSB 5
`define RIO_SEL_ROLE2_LSB 7
`define RIO_SEL_JOBACT_BIT 9
`define RIO_SEL_JOB_LSB 16

// raw input register fields
`define RIO_RAW_CFG_LSB 0
`define RIO_RAW_JOB_LSB 8
`define RIO_RAW_WM_LSB 16
`define RIO_RAW_OP_LSB 21
`define RIO_RAW_AUX_LSB 23

// interrupt event bits
`define RIO_IRQ_CFG_BIT 0
`define RIO_IRQ_WM_BIT 1
`define RIO_IRQ_OP_BIT 2
`define RIO_IRQ_BAD_BIT 3
`define RIO_IRQ_COLL_BIT 4
`define RIO_IRQ_W 5
`define RIO_IRQ_MASK_RST 5'h00

// control register
`define RIO_CTRL_FALLBACK_BIT 0
`define RIO_CTRL_RST 1'h1

// input codes
`define RIO_CFG_CODE_JOB 8'h01
`define RIO_CFG_CODE_SYN 8'h10
`define RIO_WM_CODE_INTERNAL 5'h00
`define RIO_WM_CODE_SPECIAL 5'h01
`define RIO_WM_CODE_JOB 5'h02
`define RIO_WM_CODE_STD 5'h08
`define RIO_OP_CODE_SINGLE1 2'h0
`define RIO_OP_CODE_LEAD1 2'h1
`define RIO_OP_CODE_TRAIL1 2'h2
`define RIO_OP_CODE_SINGLE2 2'h3

// core status vector bit positions
`define RIO_ST_FLOW 0
`define RIO_ST_ACTIVE 1
`define RIO_ST_MAIN 2
`define RIO_ST_COLL 3
`define RIO_ST_BREAK 4
`define RIO_ST_READY 5
`define RIO_ST_LIMIT 6
`define RIO_ST_W 7

`endif

// ---- include/rio_pkg.sv ----
// robot i/o mode decoder: decoded selection types
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package rio_pkg;
	typedef enum logic [1:0] {
		cfg_none = 2'b00,
		cfg_retro_job = 2'b01,
		cfg_retro_syn_job = 2'b10
	} rio_cfg_type;

	typedef enum logic [2:0] {
		wm_internal = 3'b000,
		wm_special = 3'b001,
		wm_job = 3'b010,
		wm_std = 3'b011,
		wm_invalid = 3'b100
	} rio_wm_type;

	typedef enum logic [1:0] {
		role_off = 2'b00,
		role_single = 2'b01,
		leading_arc_role = 2'b10,
		trailing_arc_role = 2'b11
	} rio_role_type;
endpackage
`default_nettype wire

// ---- logic/rio_sync.sv ----
// two-flop synchroniser for a vector of static levels
// assumes each bit is a slow level; bits may settle on different edges
`default_nettype none
module rio_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- logic/rio_decode.sv ----
// combinational decode of configuration, working mode and twin operating mode
// assumes synchronised inputs; results are registered by the caller
`include "rio_consts.svh"
`default_nettype none
module rio_decode
	import rio_pkg::*;
(
	// raw codes
	input wire logic [7:0] cfg_code,
	input wire logic [4:0] wm_code,
	input wire logic [1:0] op_code,
	// unknown working-mode codes fall back to internal selection when set
	input wire logic fallback,
	// decoded
	output rio_cfg_type cfg_sel,
	output rio_wm_type wm_sel,
	output rio_role_type role1,
	output rio_role_type role2,
	output logic bad_code
);
	always_comb
	begin
		case (cfg_code)
			`RIO_CFG_CODE_JOB: cfg_sel = cfg_retro_job;
			`RIO_CFG_CODE_SYN: cfg_sel = cfg_retro_syn_job;
			default: cfg_sel = cfg_none;
		endcase
	end

	always_comb
	begin
		case (wm_code)
			`RIO_WM_CODE_INTERNAL: wm_sel = wm_internal;
			`RIO_WM_CODE_STD: wm_sel = wm_std;
			`RIO_WM_CODE_SPECIAL: wm_sel = wm_special;
			`RIO_WM_CODE_JOB: wm_sel = wm_job;
			default: wm_sel = fallback ? wm_internal : wm_invalid;
		endcase
	end

	always_comb
	begin
		case (op_code)
			`RIO_OP_CODE_SINGLE1:
			begin
				role1 = role_single;
				role2 = role_off;
			end
			`RIO_OP_CODE_LEAD1:
			begin
				role1 = leading_arc_role;
				role2 = trailing_arc_role;
			end
			`RIO_OP_CODE_TRAIL1:
			begin
				role1 = trailing_arc_role;
				role2 = leading_arc_role;
			end
			default:
			begin
				role1 = role_off;
				role2 = role_single;
			end
		endcase
	end

	always_comb
	begin
		bad_code = (cfg_sel == cfg_none) || !(wm_code inside {`RIO_WM_CODE_INTERNAL,
			`RIO_WM_CODE_STD, `RIO_WM_CODE_SPECIAL, `RIO_WM_CODE_JOB});
	end
endmodule
`default_nettype wire

// ---- logic/rio_top.sv ----
// robot i/o mode decoder top: pin sampling, decoded selections, status outputs,
// avalon-mm register slave and interrupt
// assumes robot and power-source status pins are asynchronous static levels
//
// What this block does
// - config bit 0 alone selects retrofit job
// - config bit 4 alone selects retrofit synergic job
// - working-mode zero selects internal parameter selection
// - working-mode bit 3 alone selects standard two-step
// - bit 0 special two-step; bit 1 job mode
// - twin code assigns roles of both sources
// - collision output low on collision or cable break
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`include "rio_consts.svh"
`default_nettype none
module rio_top
	import rio_pkg::*;
#(
	parameter int JOB_W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// robot digital inputs
	input wire logic [7:0] cfg_in,
	input wire logic [4:0] wm_in,
	input wire logic [1:0] op_in,
	input wire logic [JOB_W-1:0] job_in,
	input wire logic [8:0] aux_in,
	// power source status levels
	input wire logic current_flow_in,
	input wire logic process_active_in,
	input wire logic main_current_in,
	input wire logic collision_in,
	input wire logic cable_break_in,
	input wire logic source_ready_in,
	input wire logic limit_in,
	// decoded selections
	output rio_cfg_type cfg_q,
	output rio_wm_type wm_q,
	output rio_role_type role1_q,
	output rio_role_type role2_q,
	output logic job_active_q,
	output logic [JOB_W-1:0] job_index_q,
	// status outputs to the robot
	output logic current_flow_q,
	output logic process_active_q,
	output logic main_current_q,
	output logic collision_ok_q,
	output logic source_ready_q,
	output logic limit_q,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// interrupt
	output logic irq_q
);
	logic [7:0] cfg_s;
	logic [4:0] wm_s;
	logic [1:0] op_s;
	logic [JOB_W-1:0] job_s;
	logic [8:0] aux_s;
	logic [`RIO_ST_W-1:0] st_s;
	rio_cfg_type cfg_d;
	rio_wm_type wm_d;
	rio_role_type role1_d;
	rio_role_type role2_d;
	logic bad_d;
	logic bad_q;
	logic fallback_q;
	logic [`RIO_IRQ_W-1:0] irq_stat_q;
	logic [`RIO_IRQ_W-1:0] irq_mask_q;
	logic [`RIO_IRQ_W-1:0] ev_d;
	logic coll_d;
	logic acc_q;
	logic wr_ack;
	logic [31:0] rd_d;

	////////////////////////////////////////////////////////////////////////////
	// pin sampling: every pin passes two flops before any decode

	rio_sync #(
		.W(24 + JOB_W)
	) u_robot_sync (
		.mclk(mclk),
		.nrst(nrst),
		.async_in({aux_in, job_in, op_in, wm_in, cfg_in}),
		.sync_out({aux_s, job_s, op_s, wm_s, cfg_s})
	);

	rio_sync #(
		.W(`RIO_ST_W)
	) u_status_sync (
		.mclk(mclk),
		.nrst(nrst),
		.async_in({limit_in, source_ready_in, cable_break_in, collision_in,
			main_current_in, process_active_in, current_flow_in}),
		.sync_out(st_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode and registered selections

	rio_decode u_decode (
		.cfg_code(cfg_s),
		.wm_code(wm_s),
		.op_code(op_s),
		.fallback(fallback_q),
		.cfg_sel(cfg_d),
		.wm_sel(wm_d),
		.role1(role1_d),
		.role2(role2_d),
		.bad_code(bad_d)
	);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_q <= cfg_none;
			wm_q <= wm_internal;
			role1_q <= role_single;
			role2_q <= role_off;
			bad_q <= 1'b0;
		end
		else
		begin
			cfg_q <= cfg_d;
			wm_q <= wm_d;
			role1_q <= role1_d;
			role2_q <= role2_d;
			bad_q <= bad_d;
		end
	end

	// the index holds its last value outside job mode so a mode blip keeps the job
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			job_active_q <= 1'b0;
			job_index_q <= '0;
		end
		else
		begin
			job_active_q <= (wm_d == wm_job);
			if (wm_d == wm_job)
			begin
				job_index_q <= job_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status outputs to the robot

	assign coll_d = st_s[`RIO_ST_COLL] | st_s[`RIO_ST_BREAK];

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			current_flow_q <= 1'b0;
			process_active_q <= 1'b0;
			main_current_q <= 1'b0;
			collision_ok_q <= 1'b0;
			source_ready_q <= 1'b0;
			limit_q <= 1'b0;
		end
		else
		begin
			current_flow_q <= st_s[`RIO_ST_FLOW];
			process_active_q <= st_s[`RIO_ST_ACTIVE];
			main_current_q <= st_s[`RIO_ST_MAIN];
			collision_ok_q <= !coll_d;
			source_ready_q <= st_s[`RIO_ST_READY];
			limit_q <= st_s[`RIO_ST_LIMIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt events, sticky status and mask

	always_comb
	begin
		ev_d = '0;
		ev_d[`RIO_IRQ_CFG_BIT] = (cfg_d != cfg_q);
		ev_d[`RIO_IRQ_WM_BIT] = (wm_d != wm_q);
		ev_d[`RIO_IRQ_OP_BIT] = (role1_d != role1_q);
		ev_d[`RIO_IRQ_BAD_BIT] = bad_d & !bad_q;
		ev_d[`RIO_IRQ_COLL_BIT] = coll_d & collision_ok_q;
	end

	assign wr_ack = avs_write & !avs_waitrequest;

	// a new event in the clearing cycle survives the write-one-to-clear
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_stat_q <= '0;
		end
		else
		begin
			if (wr_ack && avs_address == `RIO_OFS_IRQ_STAT)
			begin
				irq_stat_q <= (irq_stat_q & ~avs_writedata[`RIO_IRQ_W-1:0]) | ev_d;
			end
			else
			begin
				irq_stat_q <= irq_stat_q | ev_d;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_mask_q <= `RIO_IRQ_MASK_RST;
			fallback_q <= `RIO_CTRL_RST;
		end
		else if (wr_ack)
		begin
			if (avs_address == `RIO_OFS_IRQ_MASK)
			begin
				irq_mask_q <= avs_writedata[`RIO_IRQ_W-1:0];
			end
			if (avs_address == `RIO_OFS_CTRL)
			begin
				fallback_q <= avs_writedata[`RIO_CTRL_FALLBACK_BIT];
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// avalon-mm slave: one wait cycle, then waitrequest low for one cycle

	always_comb
	begin
		rd_d = '0;
		case (avs_address)
			`RIO_OFS_SEL:
			begin
				rd_d[`RIO_SEL_CFG_LSB +: 2] = cfg_q;
				rd_d[`RIO_SEL_WM_LSB +: 3] = wm_q;
				rd_d[`RIO_SEL_ROLE1_LSB +: 2] = role1_q;
				rd_d[`RIO_SEL_ROLE2_LSB +: 2] = role2_q;
				rd_d[`RIO_SEL_JOBACT_BIT] = job_active_q;
				rd_d[`RIO_SEL_JOB_LSB +: JOB_W] = job_index_q;
			end
			`RIO_OFS_RAW:
			begin
				rd_d[`RIO_RAW_CFG_LSB +: 8] = cfg_s;
				rd_d[`RIO_RAW_JOB_LSB +: JOB_W] = job_s;
				rd_d[`RIO_RAW_WM_LSB +: 5] = wm_s;
				rd_d[`RIO_RAW_OP_LSB +: 2] = op_s;
				rd_d[`RIO_RAW_AUX_LSB +: 9] = aux_s;
			end
			`RIO_OFS_IRQ_STAT: rd_d[`RIO_IRQ_W-1:0] = irq_stat_q;
			`RIO_OFS_IRQ_MASK: rd_d[`RIO_IRQ_W-1:0] = irq_mask_q;
			`RIO_OFS_CTRL: rd_d[`RIO_CTRL_FALLBACK_BIT] = fallback_q;
			default: rd_d = '0;
		endcase
	end

	assign acc_q = !avs_waitrequest;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end
		else
		begin
			avs_waitrequest <= !((avs_read | avs_write) & !acc_q);
			if (avs_read && !acc_q)
			begin
				avs_readdata <= rd_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	cfg_job_a: assert property ((cfg_in == `RIO_CFG_CODE_JOB)[*3] |=> cfg_q == cfg_retro_job)
		else $error("retrofit job config not selected");
	cfg_syn_a: assert property ((cfg_in == `RIO_CFG_CODE_SYN)[*3] |=> cfg_q == cfg_retro_syn_job)
		else $error("retrofit synergic job config not selected");
	wm_internal_a: assert property ((wm_in == `RIO_WM_CODE_INTERNAL)[*3] |=> wm_q == wm_internal)
		else $error("internal selection not decoded");
	wm_std_a: assert property ((wm_in == `RIO_WM_CODE_STD)[*3] |=> wm_q == wm_std)
		else $error("two-step mode not decoded");
	wm_special_a: assert property ((wm_in == `RIO_WM_CODE_SPECIAL)[*3] |=> wm_q == wm_special)
		else $error("special two-step not decoded");
	wm_job_a: assert property ((wm_in == `RIO_WM_CODE_JOB)[*3] |=> wm_q == wm_job && job_active_q)
		else $error("job mode not decoded");
	role_lead_a: assert property ((op_in == `RIO_OP_CODE_LEAD1)[*3] |=>
		role1_q == leading_arc_role && role2_q == trailing_arc_role)
		else $error("lead and trail roles wrong");
	role_swap_a: assert property ((op_in == `RIO_OP_CODE_SINGLE2)[*3] |=>
		role1_q == role_off && role2_q == role_single)
		else $error("source 2 single roles wrong");
	collision_out_a: assert property ((collision_in | cable_break_in)[*3] |=> !collision_ok_q)
		else $error("collision output not low");
	job_index_a: assert property ((wm_in == `RIO_WM_CODE_JOB && $stable(job_in))[*3] |=>
		job_index_q == $past(job_in))
		else $error("job index does not follow inputs");
endmodule
`default_nettype wire

// ---- dv/rio_robot_model.sv ----
// robot control unit model: parallel inputs and power-source status levels
// assumes the bench hands it wanted levels just after a rising mclk edge
`default_nettype none
module rio_robot_model (
	// clock
	input wire logic mclk,
	// wanted levels, packed like the raw input register
	input wire logic [31:0] want,
	input wire logic [6:0] want_st,
	// pins toward the decoder
	output logic [7:0] cfg_in,
	output logic [4:0] wm_in,
	output logic [1:0] op_in,
	output logic [7:0] job_in,
	output logic [8:0] aux_in,
	output logic [6:0] st_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// levels move only at an edge, as a real output card would
	always_ff @(posedge mclk)
	begin
		cfg_in <= want[7:0];
		job_in <= want[15:8];
		wm_in <= want[20:16];
		op_in <= want[22:21];
		aux_in <= want[31:23];
		st_in <= want_st;
	end
endmodule
`default_nettype wire

// ---- dv/tb_robot_io_mode_decoder.sv ----
// self-checking bench for the robot i/o mode decoder: pins, registers, interrupt
// assumes rio_pkg compiled first and rio_consts.svh on the include path
`include "rio_consts.svh"
`default_nettype none
module tb_robot_io_mode_decoder
	import rio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, pin_chk, fb, e_irq, avs_read, avs_write, avs_waitrequest;
	logic job_active_q, current_flow_q, process_active_q, main_current_q;
	logic collision_ok_q, source_ready_q, limit_q, irq_q;
	logic [31:0] want, pins_v, got, e, avs_writedata, avs_readdata;
	logic [6:0] st, st_in;
	logic [7:0] cfg_in, job_in, job_index_q, e_job;
	logic [4:0] wm_in, avs_address;
	logic [1:0] op_in;
	logic [8:0] aux_in;
	logic [15:0] lf;
	rio_cfg_type cfg_q, e_cfg;
	rio_wm_type wm_q, e_wm;
	rio_role_type role1_q, role2_q, e_r1, e_r2;
	logic [31:0] exp_q[$];
	int mismatches = 0;
	int num_checks = 0;
	logic [7:0] cfgs [6] = '{8'h01, 8'h10, 8'h00, 8'h03, 8'h11, 8'h80};
	logic [4:0] wms [6] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h1f, 5'h04};
	rio_role_type r1t [4] = '{role_single, leading_arc_role, trailing_arc_role, role_off};
	rio_role_type r2t [4] = '{role_off, trailing_arc_role, leading_arc_role, role_single};

	rio_robot_model robot (.mclk(mclk), .want(want), .want_st(st), .cfg_in(cfg_in),
		.wm_in(wm_in), .op_in(op_in), .job_in(job_in), .aux_in(aux_in), .st_in(st_in));

	rio_top #(.JOB_W(8)) DUT (.mclk(mclk), .nrst(nrst), .cfg_in(cfg_in), .wm_in(wm_in),
		.op_in(op_in), .job_in(job_in), .aux_in(aux_in), .current_flow_in(st_in[0]),
		.process_active_in(st_in[1]), .main_current_in(st_in[2]),
		.collision_in(st_in[3]), .cable_break_in(st_in[4]), .source_ready_in(st_in[5]),
		.limit_in(st_in[6]), .cfg_q(cfg_q), .wm_q(wm_q), .role1_q(role1_q),
		.role2_q(role2_q), .job_active_q(job_active_q), .job_index_q(job_index_q),
		.current_flow_q(current_flow_q), .process_active_q(process_active_q),
		.main_current_q(main_current_q), .collision_ok_q(collision_ok_q),
		.source_ready_q(source_ready_q), .limit_q(limit_q), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_q(irq_q));

	// output ports packed like the selection register, status on top
	assign pins_v = {1'b0, limit_q, source_ready_q, main_current_q, process_active_q,
		current_flow_q, irq_q, collision_ok_q, job_index_q, 6'h00, job_active_q,
		role2_q, role1_q, wm_q, cfg_q};

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] sel_w();
		return {8'h00, e_job, 6'h00, e_wm == wm_job, e_r2, e_r1, e_wm, e_cfg};
	endfunction

	task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// one avalon-mm cycle; held until waitrequest is sampled low, only the watchdog ends a hang
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
	begin
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
		begin
			@(posedge mclk);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// idle edge so the next call never re-raises a strobe in the same step
		@(posedge mclk);
	end
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] x);
	begin
		exp_q.push_back(x);
		bus(1'b0, a, 32'h0);
	end
	endtask

	// long enough for model edge, two sync flops, decode, status and irq flops
	task automatic settle;
		logic [31:0] s;
	begin
		repeat (8) @(posedge mclk);
		s = sel_w();
		exp_q.push_back({1'b0, st[6], st[5], st[2:0], e_irq, !(st[3] | st[4]), s[23:0]});
		pin_chk <= 1'b1;
		@(posedge mclk);
		pin_chk <= 1'b0;
	end
	endtask

	task automatic pins(input logic [7:0] c, input logic [4:0] w, input logic [1:0] o,
		input logic [7:0] j);
	begin
		want <= {want[31:23], o, w, j, c};
		e_cfg = c == 8'h01 ? cfg_retro_job : c == 8'h10 ? cfg_retro_syn_job : cfg_none;
		case (w)
			5'h00: e_wm = wm_internal;
			5'h01: e_wm = wm_special;
			5'h02: e_wm = wm_job;
			5'h08: e_wm = wm_std;
			default: e_wm = fb ? wm_internal : wm_invalid;
		endcase
		e_r1 = r1t[o];
		e_r2 = r2t[o];
		if (e_wm == wm_job)
			e_job = j;
		settle;
	end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk)
	begin
		if ((avs_read && avs_waitrequest === 1'b0) || pin_chk)
		begin
			got = pin_chk ? pins_v : avs_readdata;
			e = exp_q.pop_front();
			num_checks++;
			if (got !== e)
			begin
				mismatches++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
			end
		end
	end

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// 29 settles of 9 cycles plus bus traffic; generous margin
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		report_and_stop;
	end

	initial
	begin
		nrst = 1'b0;
		pin_chk = 1'b0;
		want = 32'h0;
		st = 7'h00;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		fb = 1'b1;
		e_irq = 1'b0;
		e_job = 8'h00;
		lf = 16'h9276;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		rd(`RIO_OFS_CTRL, 32'h1);
		rd(`RIO_OFS_IRQ_MASK, 32'h0);
		rd(`RIO_OFS_SEL, 32'h20);
		bus(1'b1, 5'h14, 32'hffffffff);
		rd(5'h14, 32'h0);
		$display("test reset done");
		foreach (cfgs[i]) pins(cfgs[i], 5'h00, 2'h0, 8'h00);
		$display("test config done");
		foreach (wms[i]) pins(8'h01, wms[i], 2'h0, 8'h00);
		bus(1'b1, `RIO_OFS_CTRL, 32'h0);
		fb = 1'b0;
		pins(8'h01, 5'h1f, 2'h0, 8'h00);
		bus(1'b1, `RIO_OFS_CTRL, 32'h1);
		fb = 1'b1;
		$display("test mode done");
		for (int i = 0; i < 4; i++) pins(8'h10, 5'h08, i[1:0], 8'h00);
		$display("test roles done");
		repeat (4)
		begin
			lf = nxt(lf);
			pins(8'h01, 5'h02, 2'h1, lf[7:0]);
			pins(8'h01, 5'h00, 2'h1, lf[15:8]);
		end
		rd(`RIO_OFS_SEL, sel_w());
		$display("test job done");
		lf = nxt(lf);
		want <= {lf[8:0], want[22:0]};
		st <= lf[15:9] & 7'h67;
		settle;
		rd(`RIO_OFS_RAW, want);
		$display("test raw done");
		// config, mode and role changes plus the invalid code after reset, no collision yet
		rd(`RIO_OFS_IRQ_STAT, 32'h0f);
		bus(1'b1, `RIO_OFS_IRQ_STAT, 32'h1f);
		rd(`RIO_OFS_IRQ_STAT, 32'h0);
		bus(1'b1, `RIO_OFS_IRQ_MASK, 32'h10);
		rd(`RIO_OFS_IRQ_MASK, 32'h10);
		st <= 7'h08;
		e_irq = 1'b1;
		settle;
		rd(`RIO_OFS_IRQ_STAT, 32'h10);
		bus(1'b1, `RIO_OFS_IRQ_STAT, 32'h10);
		bus(1'b1, `RIO_OFS_IRQ_MASK, 32'h0);
		e_irq = 1'b0;
		st <= 7'h10;
		settle;
		st <= 7'h00;
		settle;
		$display("test collision done");
		report_and_stop;
	end
endmodule
`default_nettype wire
